/* File: rtl/acs_pkg.sv */
// Package: constants and types for the conversion sequencer
package acs_pkg;

    // ****************************************************************
    // Register map (byte offsets, one aligned word each)
    // ****************************************************************
    localparam logic [7:0] ACS_CONTROL_ZERO_OFFSET       = 8'h00; // Mode control
    localparam logic [7:0] ACS_COMMAND_WORD_OFFSET       = 8'h04; // Command word, write starts
    localparam logic [7:0] ACS_STATUS_OFFSET             = 8'h08; // Busy and done flags
    localparam logic [7:0] ACS_RIGHT_UNSIGNED_OFFSET     = 8'h0c; // Right-justified view
    localparam logic [7:0] ACS_LEFT_SIGNED_OFFSET        = 8'h10; // Left-justified signed
    localparam logic [7:0] ACS_LEFT_UNSIGNED_OFFSET      = 8'h14; // Left-justified unsigned

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int ACS_CTRL_EXT_MUX_BIT  = 0;  // External multiplexing enable
    localparam int ACS_CMD_CHAN_LSB      = 0;  // Channel field 5:0
    localparam int ACS_CMD_SELECT_LSB    = 6;  // Final sample select 7:6
    localparam int ACS_CMD_SKIP_BIT      = 8;  // Amplifier skip
    localparam int ACS_STAT_BUSY_BIT     = 0;  // Conversion running
    localparam int ACS_STAT_DONE_BIT     = 1;  // Sticky done, cleared by result read

    // ****************************************************************
    // Reset values and cycle counts
    // ****************************************************************
    localparam logic [9:0]  ACS_RESULT_RESET      = 10'h000; // Result after reset
    localparam logic [1:0]  ACS_ADDR_RESET        = 2'h0;    // Mux address after reset
    localparam logic [4:0]  ACS_INITIAL_CYCLES    = 5'h02;   // Initial sample length
    localparam logic [4:0]  ACS_FINAL_BASE_CYCLES = 5'h02;   // Final sample at select 00
    localparam logic [4:0]  ACS_RESOLVE_CYCLES    = 5'h0a;   // One bit per cycle
    localparam int          ACS_RESULT_BITS       = 10;      // Result width

    // ****************************************************************
    // Types
    // ****************************************************************
    // Fields of one command word
    typedef struct packed {
        logic       amplifier_skip;      // Skip initial sample
        logic [1:0] final_sample_select; // Final sample length code
        logic [5:0] channel;             // Channel number
    } acs_command_type;

    // Register bus request
    typedef struct packed {
        logic [7:0]  addr;  // Byte address
        logic [31:0] wdata; // Write data
        logic        wr;    // Write strobe
        logic        rd;    // Read strobe
    } acs_bus_type;

    // Phase sequencer states
    typedef enum logic [1:0] {
        ACS_IDLE    = 2'b00,
        ACS_INITIAL = 2'b01,
        ACS_FINAL   = 2'b10,
        ACS_RESOLVE = 2'b11
    } acs_state_type;

endpackage : acs_pkg

/* File: rtl/acs_result_format.sv */
// Result formatter: right, left signed and left unsigned views
`timescale 1ns/100ps
`default_nettype none

module acs_result_format
    import acs_pkg::*;
(
    input  wire logic [9:0]  result,         // Stored result
    output logic      [15:0] right_unsigned, // Low-justified view
    output logic      [15:0] left_signed,    // Signed, left-justified view
    output logic      [15:0] left_unsigned   // Unsigned, left-justified view
);

    // ****************************************************************
    // Justification
    // ****************************************************************
    // Ten bits in the low positions, zeros above
    assign right_unsigned = {6'h00, result};                          // [RULE16]
    // Ten bits at the top, low six read zero
    assign left_unsigned  = {result, 6'h00};                          // [RULE2]
    // Offset binary to signed: invert top bit, magnitude in 14:6
    assign left_signed    = {~result[9], result[8:0], 6'h00};         // [RULE1]

endmodule : acs_result_format

`default_nettype wire

/* File: rtl/acs_sequencer.sv */
// Conversion sequencer: phases, external mux address, result registers
//
// Behaviour
// [RULE1] Signed left-justified view, magnitude in 14:6
// [RULE2] Unsigned left-justified view in 15:6
// [RULE3] Multi-cycle result reads are not coherent
// [RULE4] External mux only when control bit set
// [RULE5] Mux address driven from channel number
// [RULE6] Channel decodes to one of four inputs
// [RULE7] Address pins become outputs only when muxing; code also drives them as outputs per port_direction_bits otherwise
// [RULE8] Eight direct, or two plus sixteen channels; code decodes four direct inputs, or sixteen muxed channels
// [RULE9] Initial, final sample, then resolution order
// [RULE10] Initial sample exactly two cycles
// [RULE11] Final sample 2, 4, 8 or 16
// [RULE12] Ten resolution cycles, one bit each
// [RULE13] Select 00 gives two, doubling to sixteen
// [RULE14] Amplifier skip omits initial sample phase
// [RULE15] Done pulse when result is ready
// [RULE16] Right-justified unsigned view in low bits
// [RULE17] Start next edge; busy refuses new requests
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none

module acs_sequencer
    import acs_pkg::*;
(
    input  wire logic        clk,              // Converter clock, 40 MHz
    input  wire logic        rst_b,            // Asynchronous reset, active low
    input  wire logic [7:0]  reg_addr,         // Register byte address
    input  wire logic [31:0] reg_wdata,        // Register write data
    input  wire logic        reg_wr,           // Write strobe
    input  wire logic        reg_rd,           // Read strobe
    output logic      [31:0] reg_rdata,        // Read data, cycle after strobe
    input  wire logic        start_conv,       // Queue start request, one cycle
    input  wire logic [8:0]  queue_command,    // Queue command word
    input  wire logic        comparator,       // Comparator decision pin
    input  wire logic [1:0]  addr_pin_in,      // Address pins, input path
    input  wire logic [1:0]  port_direction_bits, // Port direction for pins 1:0
    input  wire logic [1:0]  port_data_out,    // Port data for pins 1:0
    output logic      [1:0]  addr_pin_out,     // Address pins, output value
    output logic      [1:0]  addr_pin_oe,      // Address pins, output enable
    output logic      [1:0]  addr_pin_sample,  // Pin levels seen as inputs
    output logic      [1:0]  input_select,     // Expanded or direct input chosen
    output logic             ext_mux_active,   // External mux mode flag
    output logic             amp_enable,       // Buffer amplifier in path
    output logic             sample_enable,    // Sample capacitor connected
    output logic      [9:0]  trial_bits,       // Approximation register to DAC
    output logic             conv_done,        // End of conversion pulse
    output logic             busy              // Conversion running
);

    // ****************************************************************
    // Reset synchroniser
    // ****************************************************************
    logic       rst_meta_b; // First reset stage
    logic       rst_sync_b; // Released reset used everywhere

    // Release reset through two flops
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // ****************************************************************
    // Pin input synchronisers
    // ****************************************************************
    logic [2:0] pin_meta;   // First stage: comparator and pins
    logic [2:0] pin_sync;   // Second stage

    // Two flops before any logic reads a pin
    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end
        else
        begin
            pin_meta <= {comparator, addr_pin_in};
            pin_sync <= pin_meta;
        end
    end

    // ****************************************************************
    // Register bus decode
    // ****************************************************************
    acs_bus_type bus;               // Bundled request
    logic        control_zero;      // External mux enable
    acs_command_type sw_command;    // Last software command word
    logic        sw_start;          // Software start pulse
    logic        done_flag;         // Sticky done
    logic [9:0]  result;            // Stored result
    logic [15:0] right_view;        // Right-justified view
    logic [15:0] left_signed_value; // Signed left view
    logic [15:0] left_unsigned_value; // Unsigned left view
    logic        result_read;       // A result register was read

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Control and command registers
    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            control_zero <= 1'b0;
            sw_command   <= '0;
            sw_start     <= 1'b0;
        end
        else
        begin
            sw_start <= 1'b0;
            if (bus.wr && bus.addr == ACS_CONTROL_ZERO_OFFSET)
            begin
                // Only software sets the mode
                control_zero <= bus.wdata[ACS_CTRL_EXT_MUX_BIT]; // [RULE4]
            end
            if (bus.wr && bus.addr == ACS_COMMAND_WORD_OFFSET)
            begin
                sw_command <= bus.wdata[8:0];
                sw_start   <= 1'b1;
            end
        end
    end

    assign result_read = bus.rd && (bus.addr == ACS_RIGHT_UNSIGNED_OFFSET
                                 || bus.addr == ACS_LEFT_SIGNED_OFFSET
                                 || bus.addr == ACS_LEFT_UNSIGNED_OFFSET);

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            reg_rdata <= 32'h0;
        end
        else if (bus.rd)
        begin
            case (bus.addr)
                ACS_CONTROL_ZERO_OFFSET:   reg_rdata <= {31'h0, control_zero};
                ACS_COMMAND_WORD_OFFSET:   reg_rdata <= {23'h0, sw_command};
                ACS_STATUS_OFFSET:         reg_rdata <= {30'h0, done_flag, busy};
                // Each word is one snapshot; no pairing across reads
                ACS_RIGHT_UNSIGNED_OFFSET: reg_rdata <= {16'h0, right_view};        // [RULE3]
                ACS_LEFT_SIGNED_OFFSET:    reg_rdata <= {16'h0, left_signed_value};
                ACS_LEFT_UNSIGNED_OFFSET:  reg_rdata <= {16'h0, left_unsigned_value};
                default:                   reg_rdata <= 32'h0;
            endcase
        end
        else
        begin
            reg_rdata <= 32'h0;
        end
    end

    // ****************************************************************
    // Phase sequencer
    // ****************************************************************
    acs_state_type   state;        // Current phase
    acs_command_type cmd;          // Latched command of this conversion
    logic [4:0]      phase_count;  // Cycles left in phase
    logic [3:0]      bit_index;    // Bit under trial
    logic [9:0]      approximation_register;          // Approximation register
    logic            start_any;    // Start from queue or software
    acs_command_type start_cmd;    // Command for a new start
    logic [4:0]      final_cycles; // Decoded final sample length

    assign start_any = start_conv || sw_start;
    assign start_cmd = start_conv ? acs_command_type'(queue_command) : sw_command;

    // Select 00..11 gives 2,4,8,16
    assign final_cycles = ACS_FINAL_BASE_CYCLES << cmd.final_sample_select; // [RULE11] [RULE13]

    // Sequence of phases
    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            state       <= ACS_IDLE;
            cmd         <= '0;
            phase_count <= 5'h0;
        end
        else
        begin
            case (state)
                ACS_IDLE:
                begin
                    // Requests only taken when idle
                    if (start_any) // [RULE17]
                    begin
                        cmd <= start_cmd;
                        if (start_cmd.amplifier_skip)
                        begin
                            // No initial phase when skipping
                            state       <= ACS_FINAL; // [RULE14]
                            phase_count <= ACS_FINAL_BASE_CYCLES
                                           << start_cmd.final_sample_select;
                        end
                        else
                        begin
                            state       <= ACS_INITIAL; // [RULE9]
                            phase_count <= ACS_INITIAL_CYCLES; // [RULE10]
                        end
                    end
                end
                ACS_INITIAL:
                begin
                    if (phase_count == 5'h1)
                    begin
                        state       <= ACS_FINAL; // [RULE9]
                        phase_count <= final_cycles;
                    end
                    else
                    begin
                        phase_count <= phase_count - 5'h1;
                    end
                end
                ACS_FINAL:
                begin
                    if (phase_count == 5'h1)
                    begin
                        state       <= ACS_RESOLVE; // [RULE9]
                        phase_count <= ACS_RESOLVE_CYCLES; // [RULE12]
                    end
                    else
                    begin
                        phase_count <= phase_count - 5'h1;
                    end
                end
                ACS_RESOLVE:
                begin
                    if (phase_count == 5'h1)
                    begin
                        state <= ACS_IDLE;
                    end
                    phase_count <= phase_count - 5'h1;
                end
                default:
                begin
                    state <= ACS_IDLE;
                end
            endcase
        end
    end

    // Successive approximation, MSB first, one bit per cycle
    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            approximation_register       <= ACS_RESULT_RESET;
            bit_index <= 4'h9;
        end
        else if (state == ACS_FINAL && phase_count == 5'h1)
        begin
            // Preload trial with MSB set
            approximation_register       <= 10'h200;
            bit_index <= 4'h9;
        end
        else if (state == ACS_RESOLVE)
        begin
            // Keep or drop trial bit, then set the next one
            approximation_register[bit_index] <= pin_sync[2]; // [RULE12]
            if (bit_index != 4'h0)
            begin
                approximation_register[bit_index - 4'h1] <= 1'b1;
                bit_index             <= bit_index - 4'h1;
            end
        end
    end

    // Store result and raise done
    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            result    <= ACS_RESULT_RESET;
            conv_done <= 1'b0;
            done_flag <= 1'b0;
        end
        else
        begin
            conv_done <= 1'b0;
            if (state == ACS_RESOLVE && phase_count == 5'h1)
            begin
                result    <= {approximation_register[9:1], pin_sync[2]};
                conv_done <= 1'b1; // [RULE15]
            end
            // Set wins over clear
            if (state == ACS_RESOLVE && phase_count == 5'h1)
                done_flag <= 1'b1;
            else if (result_read)
                done_flag <= 1'b0;
        end
    end

    assign busy          = (state != ACS_IDLE);
    assign amp_enable    = (state == ACS_INITIAL);
    assign sample_enable = (state == ACS_INITIAL) || (state == ACS_FINAL);
    assign trial_bits    = approximation_register;

    // ****************************************************************
    // External multiplexer address and input decode
    // ****************************************************************
    logic [1:0] ext_addr; // external_channel_address register

    // Address bits taken from channel 2:1 each conversion
    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            ext_addr     <= ACS_ADDR_RESET;
            input_select <= 2'h0;
        end
        else if (state == ACS_IDLE && start_any)
        begin
            ext_addr <= start_cmd.channel[2:1]; // [RULE5]
            if (control_zero)
            begin
                // Bit 4 picks w/x or y/z pair, bit 0 picks one of that pair: 16 channels
                input_select <= {start_cmd.channel[4], start_cmd.channel[0]}; // [RULE6] [RULE8]
            end
            else
            begin
                // Direct mode: low bits pick one of the direct inputs
                input_select <= start_cmd.channel[1:0]; // [RULE8]
            end
        end
    end

    assign ext_mux_active = control_zero; // [RULE4]

    // Pins forced to outputs while muxing; direction bits ignored then
    assign addr_pin_oe     = control_zero ? 2'b11 : port_direction_bits; // [RULE7]
    assign addr_pin_out    = control_zero ? ext_addr : port_data_out;    // [RULE5]
    assign addr_pin_sample = control_zero ? 2'b00 : pin_sync[1:0];       // [RULE7]

    // ****************************************************************
    // Result views
    // ****************************************************************
    acs_result_format u_format
    (
        .result         (result),
        .right_unsigned (right_view),
        .left_signed    (left_signed_value),
        .left_unsigned  (left_unsigned_value)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_INIT_TWO: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE10]
        $rose(amp_enable) |-> amp_enable [*2] ##1 !amp_enable)
        else $error("initial sample not two cycles");

    AST_SKIP: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE14]
        (state == ACS_IDLE && start_any && start_cmd.amplifier_skip) |=> state == ACS_FINAL)
        else $error("skip did not omit initial phase");

    AST_ORDER: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE9]
        (state == ACS_INITIAL && $past(state) == ACS_INITIAL) |=> state == ACS_FINAL)
        else $error("initial not followed by final");

    AST_RESOLVE_TEN: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE12]
        (state == ACS_RESOLVE && $past(state) != ACS_RESOLVE) |-> ##9 conv_done == 1'b0 ##1 conv_done)
        else $error("resolution not ten cycles");

    AST_FINAL_LEN: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE11]
        (state == ACS_FINAL && $past(state) != ACS_FINAL && cmd.final_sample_select == 2'b00)
        |-> ##1 state == ACS_FINAL ##1 state == ACS_RESOLVE)
        else $error("final sample length wrong");

    AST_DONE: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE15]
        conv_done |-> $past(state) == ACS_RESOLVE && state == ACS_IDLE && done_flag)
        else $error("done without resolution");

    AST_PINS: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE7]
        control_zero |-> addr_pin_oe == 2'b11 && addr_pin_out == ext_addr)
        else $error("address pins not outputs");

    AST_START: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE17]
        (state == ACS_IDLE && start_any) |=> busy)
        else $error("start not taken next edge");

    AST_VIEWS: assert property (@(posedge clk) disable iff (!rst_sync_b) // [RULE2]
        left_unsigned_value[15:6] == right_view[9:0] && left_unsigned_value[5:0] == 6'h00)
        else $error("views disagree");

endmodule : acs_sequencer

`default_nettype wire

/* File: testbench/acs_analog_model.sv */
// Far-side model: external mux chips and analog sources
`timescale 1ns/100ps
`default_nettype none

module acs_analog_model
    import acs_pkg::*;
(
    input  wire logic [1:0]  addr_pin_out,   // Mux address pins
    input  wire logic [1:0]  input_select,   // Converter input chosen
    input  wire logic        ext_mux_active, // Mode flag
    input  wire logic [15:0] ext_levels,     // Level behind each mux leg
    input  wire logic [3:0]  dir_levels,     // Level on each direct input
    output logic             comparator      // Full or zero scale decision
);
    // ****************************************************************
    // Chip picked by input select, leg by the shared address pins
    // ****************************************************************
    assign comparator = ext_mux_active ? ext_levels[{input_select, addr_pin_out}]
                                       : dir_levels[input_select];
endmodule : acs_analog_model

`default_nettype wire

/* File: testbench/tb_top.sv */
// Testbench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_top
    import acs_pkg::*;
;
    logic        clk, rst_b, reg_wr, reg_rd, start_conv, comparator;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [8:0]  queue_command;
    logic [1:0]  addr_pin_in, port_direction_bits, port_data_out, addr_pin_out;
    logic [1:0]  addr_pin_oe, addr_pin_sample, input_select;
    logic        ext_mux_active, amp_enable, sample_enable, conv_done, busy;
    logic [9:0]  trial_bits;
    logic [15:0] ext_levels = 16'ha5c3; // Far-side levels per mux leg
    logic [3:0]  dir_levels = 4'b0010;  // Far-side levels per direct input
    int          fail_count, n_tests, cyc, nb, na, nd, ns;
    logic [9:0]  r;

    // Pin level: our drive where enabled, far side holds 1/0 otherwise
    assign addr_pin_in = (addr_pin_oe & addr_pin_out) | (~addr_pin_oe & 2'b10);

    acs_sequencer u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .start_conv(start_conv), .queue_command(queue_command), .comparator(comparator),
        .addr_pin_in(addr_pin_in), .port_direction_bits(port_direction_bits),
        .port_data_out(port_data_out), .addr_pin_out(addr_pin_out),
        .addr_pin_oe(addr_pin_oe), .addr_pin_sample(addr_pin_sample),
        .input_select(input_select), .ext_mux_active(ext_mux_active),
        .amp_enable(amp_enable), .sample_enable(sample_enable), .trial_bits(trial_bits),
        .conv_done(conv_done), .busy(busy));

    acs_analog_model u_model (.addr_pin_out(addr_pin_out), .input_select(input_select),
        .ext_mux_active(ext_mux_active), .ext_levels(ext_levels),
        .dir_levels(dir_levels), .comparator(comparator));

    // Clock and hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            conclude();
        end
    end

    // ****************************************************************
    // Bus and check tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rd

    // One conversion; counts busy, amplifier and done cycles
    task automatic conv(input logic [8:0] cmd, input bit via_reg, input bit refuse);
        int n;
        nb = 0;
        na = 0;
        nd = 0;
        ns = 0;
        if (via_reg)
            wr(ACS_COMMAND_WORD_OFFSET, {23'h0, cmd});
        else
        begin
            @(posedge clk);
            start_conv    <= 1'b1;
            queue_command <= cmd;
            @(posedge clk);
            start_conv    <= 1'b0;
        end
        for (n = 0; n < 80 && !(nd > 0 && busy === 1'b0); n++)
        begin
            #1;
            nb += (busy === 1'b1);
            na += (amp_enable === 1'b1);
            ns += (sample_enable === 1'b1);
            nd += (conv_done === 1'b1);
            @(posedge clk);
            // Stray start while busy, driven on the edge
            start_conv <= refuse && n == 2;
        end
    endtask : conv

    task automatic conclude();
        if (fail_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {clk, rst_b, reg_wr, reg_rd, start_conv, reg_addr, reg_wdata, queue_command} = '0;
        port_direction_bits = 2'b01;
        port_data_out       = 2'b10;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd(ACS_RIGHT_UNSIGNED_OFFSET, 32'h0);
        rd(ACS_LEFT_SIGNED_OFFSET, 32'h8000);
        rd(8'h1c, 32'h0);
        check(addr_pin_oe, 2'b01);
        check(addr_pin_sample, 2'b10);
        // Every final sample code, with and without amplifier skip
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 2; k++)
            begin
                conv({k[0], s[1:0], 6'h01}, s[0], 1'b0);
                check(nb, (k ? 0 : 2) + (2 << s) + 10);
                check(na, k ? 0 : 2);
                check(ns, (k ? 0 : 2) + (2 << s));
                check(nd, 1);
                check(trial_bits, 10'h3ff);
                check(input_select, 2'b01);
                rd(ACS_STATUS_OFFSET, 32'h2);
                rd(ACS_RIGHT_UNSIGNED_OFFSET, 32'h3ff);
                rd(ACS_LEFT_UNSIGNED_OFFSET, 32'hffc0);
                rd(ACS_LEFT_SIGNED_OFFSET, 32'h7fc0);
            end
        // Start while busy is ignored, zero result
        conv(9'h040, 1'b1, 1'b1);
        check(nb, 16);
        rd(ACS_LEFT_SIGNED_OFFSET, 32'h8000);
        rd(ACS_STATUS_OFFSET, 32'h0);
        // External multiplexing: all sixteen legs
        wr(ACS_CONTROL_ZERO_OFFSET, 32'h1);
        port_direction_bits <= 2'b00;
        for (int k = 0; k < 16; k++)
        begin
            // Skip off, select 01, channel {0, k3, 0, k1, k0, k2}
            conv({3'b001, 1'b0, k[3], 1'b0, k[1:0], k[2]}, 1'b0, 1'b0);
            check(addr_pin_out, k[1:0]);
            check(input_select, k[3:2]);
            check(addr_pin_oe, 2'b11);
            check(addr_pin_sample, 2'b00);
            r = {10{ext_levels[k]}};
            rd(ACS_RIGHT_UNSIGNED_OFFSET, {22'h0, r});
        end
        conclude();
    end
endmodule : tb_top

`default_nettype wire
